// ==== rtl/eip_bank2.sv ====
`timescale 1ns/1ns
// ****************************************************************
// Interrupt mask and priority bank 2
// ****************************************************************
module eip_bank2
    import eip_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Register access from the core
    input wire eip_sfr_s sfr_in,
    output logic [SFR_W-1:0] sfr_rdata_out,
    output logic sfr_rvalid_out,
    // Peripheral requests and companion high priority bits
    input wire eip_raw_s raw_in,
    input wire eip_src_s prio_high_in,
    // Gated requests and two-bit levels to the arbiter
    output eip_src_s irq_req_out,
    output logic [NSRC*LVL_W-1:0] irq_level_out
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync_r; // Two-stage release of the async reset
    logic rst_n; // Released copy used by all state

    // Assert at once, release after two clean edges
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The level loop indexes sources by bit, so the positions must run
    // down from the top source to bit 0 inside one register
    if ((NSRC > SFR_W) || (LVL_W != 2) || (POS_LU != NSRC - 1) || (POS_UB != 0))
    begin : g_bad_layout
        $error("eip_bank2 source layout does not fit the register");
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic mask_hit; // Mask register selected
    logic prio_hit; // Low priority register selected
    logic [NSRC-1:0] req_raw; // Requests merged per source
    logic [NSRC-1:0] ph_bits; // High priority bits as a vector

    // Mask answers on either page, priority only on the extended page
    assign mask_hit = (sfr_in.addr == MASK_ADDR) &&
        ((sfr_in.page == PAGE_BASE) || (sfr_in.page == PAGE_EXT));
    assign prio_hit = (sfr_in.addr == PRIO_ADDR) && (sfr_in.page == PAGE_EXT);

    // Timer sources raise on either overflow flag
    assign req_raw[POS_LU] = raw_in.logic_unit;
    assign req_raw[POS_T5] = raw_in.timer5_low_overflow_flag
        | raw_in.timer5_high_overflow_flag;
    assign req_raw[POS_T4] = raw_in.timer4_low_overflow_flag
        | raw_in.timer4_high_overflow_flag;
    assign req_raw[POS_I2C] = raw_in.i2c_slave;
    assign req_raw[POS_UB] = raw_in.uart_b;
    assign ph_bits = prio_high_in;

    // ****************************************************************
    // State update
    // ****************************************************************
    eip_state_s st_r; // All registered state
    eip_state_s st_nxt; // Next value of the state

    // Register writes, read answer, gating and level build
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rvalid = sfr_in.rd;
        st_nxt.rdata = RDATA_IDLE;
        // Upper bits are stored as written and read back; no gating or level uses them
        if (sfr_in.wr && mask_hit)
        begin
            st_nxt.mask = sfr_in.wdata;
        end
        if (sfr_in.wr && prio_hit)
        begin
            st_nxt.prio_lo = sfr_in.wdata;
        end
        // Unmapped reads answer zero so the core never sees stale data
        if (sfr_in.rd && mask_hit)
        begin
            st_nxt.rdata = st_r.mask;
        end
        else if (sfr_in.rd && prio_hit)
        begin
            st_nxt.rdata = st_r.prio_lo;
        end
        else
        begin
            st_nxt.rdata = RDATA_IDLE;
        end
        // Gate each source by its mask bit
        st_nxt.req.logic_unit = req_raw[POS_LU] & st_r.mask[POS_LU];
        st_nxt.req.timer5 = req_raw[POS_T5] & st_r.mask[POS_T5];
        st_nxt.req.timer4 = req_raw[POS_T4] & st_r.mask[POS_T4];
        st_nxt.req.i2c_slave = req_raw[POS_I2C] & st_r.mask[POS_I2C];
        st_nxt.req.uart_b = req_raw[POS_UB] & st_r.mask[POS_UB];
        // Level is high bit from the companion register over our low bit
        for (int i = 0; i < NSRC; i++)
        begin
            st_nxt.level[i*LVL_W +: LVL_W] = {ph_bits[i], st_r.prio_lo[i]};
        end
    end

    // Single state register
    always_ff @(posedge sys_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.mask <= REG_RST;
            st_r.prio_lo <= REG_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sfr_rdata_out = st_r.rdata;
    assign sfr_rvalid_out = st_r.rvalid;
    assign irq_req_out = st_r.req;
    assign irq_level_out = st_r.level;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n);

    // Unmasked logic unit request appears next cycle
    property p_lu_pass;
        (raw_in.logic_unit && st_r.mask[POS_LU]) |=> irq_req_out.logic_unit;
    endproperty
    a_lu_pass: assert property (p_lu_pass) else $error("logic unit pass");

    // High timer5 flag passes when enabled
    property p_t5_flags;
        (raw_in.timer5_high_overflow_flag && st_r.mask[POS_T5]) ##1 1'b1
            |-> irq_req_out.timer5;
    endproperty
    a_t5_flags: assert property (p_t5_flags) else $error("timer5 flag lost");

    // Timer4 blocked while its mask is clear
    property p_t4_block;
        !st_r.mask[POS_T4] |=> !irq_req_out.timer4;
    endproperty
    a_t4_block: assert property (p_t4_block) else $error("timer4 leaked");

    // I2C request follows raw request and mask together
    property p_i2c_gate;
        // Sampled reset skips the release edge, where state still shows reset
        rst_n |=> irq_req_out.i2c_slave ==
            ($past(raw_in.i2c_slave) && $past(st_r.mask[POS_I2C]));
    endproperty
    a_i2c_gate: assert property (p_i2c_gate) else $error("i2c gate wrong");

    // Second UART gated by bit 0
    property p_ub_gate;
        (raw_in.uart_b && !st_r.mask[POS_UB]) |=> !irq_req_out.uart_b;
    endproperty
    a_ub_gate: assert property (p_ub_gate) else $error("uart_b leaked");

    // Mask write on the base page lands in the register
    property p_mask_base;
        (sfr_in.wr && sfr_in.addr == MASK_ADDR && sfr_in.page == PAGE_BASE)
            |=> st_r.mask == $past(sfr_in.wdata);
    endproperty
    a_mask_base: assert property (p_mask_base) else $error("mask write lost");

    // Priority register ignores the base page
    property p_prio_page;
        (sfr_in.wr && sfr_in.addr == PRIO_ADDR && sfr_in.page == PAGE_BASE)
            |=> $stable(st_r.prio_lo);
    endproperty
    a_prio_page: assert property (p_prio_page) else $error("prio wrong page");

    // Written low priority bit reaches the level two cycles later
    property p_lsb_level;
        (sfr_in.wr && prio_hit) ##2 1'b1
            |-> irq_level_out[POS_LU*LVL_W] == $past(sfr_in.wdata[POS_LU], 2)
            && irq_level_out[POS_UB*LVL_W] == $past(sfr_in.wdata[POS_UB], 2);
    endproperty
    a_lsb_level: assert property (p_lsb_level) else $error("level lsb wrong");

    // High bit of the timer5 and I2C levels follows the companion register
    property p_msb_level;
        // Companion bits may be set across a reset, so skip the release edge
        rst_n |=> irq_level_out[POS_T5*LVL_W+1] == $past(ph_bits[POS_T5])
            && irq_level_out[POS_I2C*LVL_W+1] == $past(ph_bits[POS_I2C]);
    endproperty
    a_msb_level: assert property (p_msb_level) else $error("level msb wrong");

    // Read of the mask returns stored value next cycle
    property p_mask_read;
        (sfr_in.rd && mask_hit && !sfr_in.wr) |=> sfr_rvalid_out
            && sfr_rdata_out == $past(st_r.mask);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

    // Low timer5 flag passes as well as the high one
    property p_t5_low;
        (raw_in.timer5_low_overflow_flag && st_r.mask[POS_T5]) |=> irq_req_out.timer5;
    endproperty
    a_t5_low: assert property (p_t5_low) else $error("timer5 low flag lost");

    // Either timer4 flag passes when enabled
    property p_t4_pass;
        ((raw_in.timer4_low_overflow_flag || raw_in.timer4_high_overflow_flag)
            && st_r.mask[POS_T4]) |=> irq_req_out.timer4;
    endproperty
    a_t4_pass: assert property (p_t4_pass) else $error("timer4 flag lost");

    // Logic unit blocked while its mask is clear
    property p_lu_block;
        !st_r.mask[POS_LU] |=> !irq_req_out.logic_unit;
    endproperty
    a_lu_block: assert property (p_lu_block) else $error("logic unit leaked");

    // Second UART passes when bit 0 is set
    property p_ub_pass;
        (raw_in.uart_b && st_r.mask[POS_UB]) |=> irq_req_out.uart_b;
    endproperty
    a_ub_pass: assert property (p_ub_pass) else $error("uart_b lost");

    // Mask write on the extended page lands as well
    property p_mask_ext;
        (sfr_in.wr && sfr_in.addr == MASK_ADDR && sfr_in.page == PAGE_EXT)
            |=> st_r.mask == $past(sfr_in.wdata);
    endproperty
    a_mask_ext: assert property (p_mask_ext) else $error("mask ext write lost");

    // Priority write on the extended page lands
    property p_prio_ext;
        (sfr_in.wr && sfr_in.addr == PRIO_ADDR && sfr_in.page == PAGE_EXT)
            |=> st_r.prio_lo == $past(sfr_in.wdata);
    endproperty
    a_prio_ext: assert property (p_prio_ext) else $error("prio write lost");

    // Middle low priority bits reach their levels two cycles later
    property p_mid_lsb;
        (sfr_in.wr && prio_hit) ##2 1'b1
            |-> irq_level_out[POS_T5*LVL_W] == $past(sfr_in.wdata[POS_T5], 2)
            && irq_level_out[POS_T4*LVL_W] == $past(sfr_in.wdata[POS_T4], 2)
            && irq_level_out[POS_I2C*LVL_W] == $past(sfr_in.wdata[POS_I2C], 2);
    endproperty
    a_mid_lsb: assert property (p_mid_lsb) else $error("middle lsb wrong");

    // Priority read returns the stored value next cycle
    property p_prio_read;
        (sfr_in.rd && prio_hit) |=> sfr_rvalid_out
            && sfr_rdata_out == $past(st_r.prio_lo);
    endproperty
    a_prio_read: assert property (p_prio_read) else $error("prio read wrong");

    // Reads that hit nothing answer valid with idle data
    property p_rd_miss;
        (sfr_in.rd && !mask_hit && !prio_hit) |=> sfr_rvalid_out
            && sfr_rdata_out == RDATA_IDLE;
    endproperty
    a_rd_miss: assert property (p_rd_miss) else $error("missed read not idle");

    // Read answer stands exactly one cycle per strobe
    property p_rd_pulse;
        rst_n |=> sfr_rvalid_out == $past(sfr_in.rd);
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read valid wrong");

    // Main scenarios
    c_ext_mask_wr: cover property (sfr_in.wr && mask_hit && sfr_in.page == PAGE_EXT);
    c_t4_fire: cover property (irq_req_out.timer4);
    c_top_level: cover property (irq_level_out[POS_LU*LVL_W +: LVL_W] == 2'h3);
    c_prio_read: cover property (sfr_in.rd && prio_hit);
    c_ub_fire: cover property (irq_req_out.uart_b);
endmodule : eip_bank2

// ==== rtl/eip_pkg.sv ====
// ****************************************************************
// Constants and carriers for the second mask and priority bank
// ****************************************************************
package eip_pkg;
    // Register access
    localparam int SFR_W = 8;
    localparam logic [7:0] MASK_ADDR = 8'hF3;
    localparam logic [7:0] PRIO_ADDR = 8'hED;
    localparam logic [7:0] PAGE_BASE = 8'h00;
    localparam logic [7:0] PAGE_EXT = 8'h10;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    // Field positions inside both registers
    localparam int POS_LU = 4;
    localparam int POS_T5 = 3;
    localparam int POS_T4 = 2;
    localparam int POS_I2C = 1;
    localparam int POS_UB = 0;
    localparam int NSRC = 5;
    localparam int LVL_W = 2;
    // One bit per source, laid out as in the registers
    typedef struct packed {
        logic logic_unit;
        logic timer5;
        logic timer4;
        logic i2c_slave;
        logic uart_b;
    } eip_src_s;
    // Raw request lines from the peripherals
    typedef struct packed {
        logic logic_unit;
        logic timer5_low_overflow_flag;
        logic timer5_high_overflow_flag;
        logic timer4_low_overflow_flag;
        logic timer4_high_overflow_flag;
        logic i2c_slave;
        logic uart_b;
    } eip_raw_s;
    // Core special function register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [SFR_W-1:0] wdata;
    } eip_sfr_s;
    // Whole state of the bank
    typedef struct packed {
        logic [SFR_W-1:0] mask;
        logic [SFR_W-1:0] prio_lo;
        logic [SFR_W-1:0] rdata;
        logic rvalid;
        eip_src_s req;
        logic [NSRC*LVL_W-1:0] level;
    } eip_state_s;
endpackage : eip_pkg

// ==== sim/ext_irq_enable_priority_bank2_bench.sv ====
`timescale 1ns/1ns
// ****************************************************************
// Bench for the second interrupt mask and priority bank
// ****************************************************************
module ext_irq_enable_priority_bank2_bench;
    import eip_pkg::*;
    logic sys_clk_in = 1'b0; // Core clock, 8 ns
    logic rstn_in = 1'b0; // Held low at start
    eip_sfr_s sfr = '0; // Register strobes
    eip_raw_s raw = '0; // Peripheral request lines
    eip_src_s prio_high = '0; // Companion high bits
    logic [SFR_W-1:0] rdata;
    logic rvalid;
    eip_src_s irq_req;
    logic [NSRC*LVL_W-1:0] level;
    int bad_count = 0;
    int samples_checked = 0;
    int src_map [7] = '{0, 1, 2, 2, 3, 3, 4}; // Raw line to source slot
    logic [7:0] val;
    logic [7:0] lo;
    logic [4:0] hi;
    logic [9:0] exp_lvl;

    // Clock toggles every half period
    always #4 sys_clk_in = ~sys_clk_in;

    eip_bank2 dut
    (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .sfr_in(sfr),
        .sfr_rdata_out(rdata),
        .sfr_rvalid_out(rvalid),
        .raw_in(raw),
        .prio_high_in(prio_high),
        .irq_req_out(irq_req),
        .irq_level_out(level)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Compare and count; four-state so an unknown never matches
    task chk(input logic [9:0] seen, input logic [9:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Verdict in one place only
    task close_out;
        $display("Compares %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // One-cycle write strobe, taken at the second edge
    task reg_wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk_in);
        sfr.wr <= 1'b1;
        sfr.page <= page;
        sfr.addr <= addr;
        sfr.wdata <= data;
        @(posedge sys_clk_in);
        sfr.wr <= 1'b0;
    endtask : reg_wr

    // Read answer stands only the cycle after the strobe edge
    task reg_rd(input logic [7:0] page, input logic [7:0] addr, output logic [7:0] data);
        @(posedge sys_clk_in);
        sfr.rd <= 1'b1;
        sfr.page <= page;
        sfr.addr <= addr;
        @(posedge sys_clk_in);
        sfr.rd <= 1'b0;
        #1;
        chk(10'(rvalid), 10'h001, "read valid");
        data = rdata;
        // Answer stands one cycle only, then drops back to idle
        @(posedge sys_clk_in);
        #1;
        chk({rvalid, 1'b0, rdata}, 10'(RDATA_IDLE), "read idle");
    endtask : reg_rd

    // Apply raw lines, then look one registered cycle later
    task raw_set(input logic [6:0] v);
        @(posedge sys_clk_in);
        raw <= v;
        @(posedge sys_clk_in);
        #1;
    endtask : raw_set

    // Bounded run; a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        bad_count++;
        close_out();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reg_rd(PAGE_BASE, MASK_ADDR, val);
        chk(10'(val), 10'(REG_RST), "mask reset");
        reg_rd(PAGE_EXT, PRIO_ADDR, val);
        chk(10'(val), 10'(REG_RST), "prio reset");
        // Mask reachable from both pages
        reg_wr(PAGE_BASE, MASK_ADDR, 8'h15);
        reg_rd(PAGE_EXT, MASK_ADDR, val);
        chk(10'(val), 10'h015, "mask page ext");
        reg_wr(PAGE_EXT, MASK_ADDR, 8'h0A);
        reg_rd(PAGE_BASE, MASK_ADDR, val);
        chk(10'(val), 10'h00A, "mask page base");
        // Priority only on the extended page; base page write ignored
        reg_wr(PAGE_EXT, PRIO_ADDR, 8'h0A);
        reg_wr(PAGE_BASE, PRIO_ADDR, 8'h1F);
        reg_rd(PAGE_EXT, PRIO_ADDR, val);
        chk(10'(val), 10'h00A, "prio kept");
        reg_rd(PAGE_BASE, PRIO_ADDR, val);
        chk(10'(val), 10'(RDATA_IDLE), "prio base page");
        reg_rd(PAGE_EXT, 8'h00, val);
        chk(10'(val), 10'(RDATA_IDLE), "unmapped read");
        // Every raw line passes when enabled, blocked when its bit clears
        for (int j = 0; j < 7; j++)
        begin
            reg_wr(PAGE_EXT, MASK_ADDR, 8'h1F);
            raw_set(7'(1 << j));
            chk(10'(irq_req), 10'(1 << src_map[j]), "request pass");
            reg_wr(PAGE_BASE, MASK_ADDR, 8'(8'h1F ^ (1 << src_map[j])));
            @(posedge sys_clk_in);
            #1;
            chk(10'(irq_req), 10'h000, "request blocked");
            raw_set(7'h00);
        end
        // Levels pair each high bit with its low bit, both polarities
        for (int k = 0; k < 2; k++)
        begin
            lo = (k == 0) ? 8'h0A : 8'h15;
            hi = (k == 0) ? 5'h15 : 5'h0A;
            reg_wr(PAGE_EXT, PRIO_ADDR, lo);
            prio_high <= hi;
            repeat (2) @(posedge sys_clk_in);
            #1;
            for (int i = 0; i < NSRC; i++)
            begin
                exp_lvl[2*i+1] = hi[i];
                exp_lvl[2*i] = lo[i];
            end
            chk(level, exp_lvl, "priority level");
        end
        // Mid-run reset drops requests at once and clears both registers
        reg_wr(PAGE_EXT, MASK_ADDR, 8'h1F);
        raw_set(7'h7F);
        chk(10'(irq_req), 10'h01F, "all requests pass");
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk(10'(irq_req), 10'h000, "reset drops requests");
        @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reg_rd(PAGE_BASE, MASK_ADDR, val);
        chk(10'(val), 10'(REG_RST), "mask after reset");
        reg_rd(PAGE_EXT, PRIO_ADDR, val);
        chk(10'(val), 10'(REG_RST), "prio after reset");
        chk(10'(irq_req), 10'h000, "reset mask blocks");
        raw_set(7'h00);
        close_out();
    end
endmodule : ext_irq_enable_priority_bank2_bench
